// ===== verilog/seq_host_ctrl.sv
// Host control of the microcode sequencer: program load, pause, step,
// breakpoint, restart, indirect jump and hardware fault detection.
// Assumes an AHB-Lite master on clk and sequencer datapath signals on clk.
`timescale 1ns/1ps
`default_nettype none
module seq_host_ctrl
    import seq_ctrl_pkg::*;
#(
    parameter int PC_W       = DEF_PC_W,        // Program counter width
    parameter int WORD_BYTES = DEF_WORD_BYTES,  // Bytes per instruction
    parameter int OP_LIMIT   = DEF_OP_LIMIT     // First illegal opcode
) (
    input  wire logic                   clk,
    input  wire logic                   reset,
    input  wire logic                   hsel,
    input  wire logic [31:0]            haddr,
    input  wire logic [1:0]             htrans,
    input  wire logic                   hwrite,
    input  wire logic [2:0]             hsize,
    input  wire logic [31:0]            hwdata,
    input  wire logic                   hready,
    output logic      [31:0]            hrdata,
    output logic                        hreadyout,
    output logic                        hresp,
    input  wire logic                   illegal_access,
    input  wire logic                   jump_low_we,
    input  wire logic                   jump_high_we,
    input  wire logic [7:0]             jump_data,
    output logic                        irq,
    output logic                        power_down,
    output logic                        halt_ack,
    output logic      [PC_W-1:0]        exec_pc,
    output logic      [WORD_BYTES*9-1:0] instr
);

    localparam int BI_W = $clog2(WORD_BYTES);  // Byte index width
    localparam int HI_W = PC_W - 8;            // Bank bits of the counter

    // Refuse sizes the byte and bank logic cannot serve
    if (PC_W < 9 || PC_W > 16 || WORD_BYTES < 2 || WORD_BYTES > 4) begin : g_bad
        $error("seq_host_ctrl: unsupported PC_W or WORD_BYTES");
    end

    // Register select by word offset
    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a[7:2] == off[7:2]);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Bus slave state
    logic        dphase_q;     // Data phase in progress
    logic        dwrite_q;     // Data phase is a write
    logic [7:0]  daddr_q;      // Latched register address
    logic [31:0] rd_word;      // Read mux result
    logic        wr_hc, wr_pcr, wr_pcl, wr_pch, wr_ram, wr_bl, wr_bh, wr_clr;

    // Control and status state
    logic [7:0]        hc_q;        // host_control_reg stored bits
    logic [7:0]        pcr_q;       // program_control_reg stored bits
    logic [7:0]        brk_lo_q;    // break_address_low
    logic [7:0]        brk_hi_q;    // break_address_high
    logic [PC_W-1:0]   pc_q;        // Program counter
    logic [BI_W-1:0]   bidx_q;      // Load byte index within a word
    logic              halt_ack_q;  // Pause reached
    logic              first_q;     // Next run cycle is the first after unpause
    logic              exec_v_q;    // instr holds a word that just executed
    logic              brk_flag_q;  // break_event_flag
    logic              fault_q;     // Flag was raised by a hardware fault
    logic [2:0]        err_q;       // Fault causes
    logic              irq_q;
    logic [31:0]       hrdata_q;
    logic              hready_q;
    logic              hresp_q;

    // Derived controls
    logic              chip_rst;    // whole_chip_reset held
    logic              run;         // Sequencer executes this cycle
    logic              host_ok;     // Host may touch RAM and counter
    logic              brk_hit;
    logic              fault_hit;
    logic              step_done;
    logic              ill_op, par_err;
    logic [PC_W-1:0]   brk_addr;
    logic [WORD_BYTES-1:0]   ram_be;
    logic [WORD_BYTES*9-1:0] ram_wd;

    ////////////////////////////////////////////////////////////////////////////
    // Address phase capture; one wait state so read data leave a flop
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            dphase_q <= 1'b0;
            dwrite_q <= 1'b0;
            daddr_q  <= 8'h00;
            hready_q <= 1'b1;
        end else if (dphase_q) begin
            dphase_q <= 1'b0;
            hready_q <= 1'b1;
        end else if (hsel && hready && htrans[HTRANS_ACTIVE]) begin
            dphase_q <= 1'b1;
            dwrite_q <= hwrite;
            daddr_q  <= haddr[7:0];
            hready_q <= 1'b0;
        end
    end

    // Response is always OKAY
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            hresp_q <= 1'b0;
        end else begin
            hresp_q <= 1'b0;
        end
    end

    // Write strobes, valid in the data phase while hwdata stands
    always_comb begin
        wr_hc  = dphase_q && dwrite_q && hit(daddr_q, OFF_HOST_CTRL);
        wr_pcr = dphase_q && dwrite_q && hit(daddr_q, OFF_PROG_CTRL);
        wr_pcl = dphase_q && dwrite_q && hit(daddr_q, OFF_PC_LOW);
        wr_pch = dphase_q && dwrite_q && hit(daddr_q, OFF_PC_HIGH);
        wr_ram = dphase_q && dwrite_q && hit(daddr_q, OFF_RAM_PORT);
        wr_bl  = dphase_q && dwrite_q && hit(daddr_q, OFF_BRK_LOW);
        wr_bh  = dphase_q && dwrite_q && hit(daddr_q, OFF_BRK_HIGH);
        wr_clr = dphase_q && dwrite_q && hit(daddr_q, OFF_INT_CLEAR);
    end

    // Read mux; unmapped offsets and the RAM port read as zero
    always_comb begin
        rd_word = 32'h0;
        if (hit(daddr_q, OFF_HOST_CTRL)) begin
            rd_word[7:0]        = hc_q;
            rd_word[HC_HALT_ACK] = halt_ack_q;
        end else if (hit(daddr_q, OFF_PROG_CTRL)) begin
            rd_word[7:0] = pcr_q;
        end else if (hit(daddr_q, OFF_PC_LOW)) begin
            rd_word[7:0] = pc_q[7:0];
        end else if (hit(daddr_q, OFF_PC_HIGH)) begin
            rd_word[HI_W-1:0] = pc_q[PC_W-1:8];
        end else if (hit(daddr_q, OFF_BRK_LOW)) begin
            rd_word[7:0] = brk_lo_q;
        end else if (hit(daddr_q, OFF_BRK_HIGH)) begin
            rd_word[7:0] = brk_hi_q;
        end else if (hit(daddr_q, OFF_INT_STATUS)) begin
            rd_word[IS_BRK_EVENT] = brk_flag_q;
        end else if (hit(daddr_q, OFF_ERROR)) begin
            rd_word[2:0] = err_q;
        end
    end

    // Read data register, loaded in the data phase of a read
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            hrdata_q <= 32'h0;
        end else if (dphase_q && !dwrite_q) begin
            hrdata_q <= rd_word;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Execution conditions
    always_comb begin
        chip_rst  = hc_q[HC_CHIP_RST];
        run       = !hc_q[HC_PAUSE] && !chip_rst;
        host_ok   = (hc_q[HC_PAUSE] && halt_ack_q) || chip_rst;
        brk_addr  = {brk_hi_q[HI_W-1:0], brk_lo_q};
        // Break on match unless disabled; never on the first cycle after unpause
        brk_hit   = run && !first_q && !brk_hi_q[BRK_DISABLE]
                    && (pc_q == brk_addr);
        // Faults from the word just executed or the datapath, unless masked
        fault_hit = exec_v_q && !pcr_q[PC_FAULT_DIS]
                    && (ill_op || par_err || illegal_access);
        step_done = run && pcr_q[PC_STEP] && !brk_hit;
    end

    // Fault checker on the fetched word
    fault_check #(
        .LANES    (WORD_BYTES),
        .OP_LIMIT (OP_LIMIT)
    ) u_fault (
        .word       (instr),
        .parity_en  (pcr_q[PC_PAR_EN]),
        .illegal_op (ill_op),
        .parity_err (par_err)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Host control: pause, chip reset, power down
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            hc_q <= HOST_CTRL_RST;
        end else begin
            if (wr_hc) begin
                hc_q <= hwdata[7:0];
                hc_q[HC_HALT_ACK] <= 1'b0;
            end
            // Hardware pause requests win over a host clear
            if (brk_hit || fault_hit || step_done) begin
                hc_q[HC_PAUSE] <= 1'b1;
            end
        end
    end

    // Acknowledge follows pause once the counter is frozen
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            halt_ack_q <= 1'b0;
        end else begin
            halt_ack_q <= hc_q[HC_PAUSE] && !(wr_hc && !hwdata[HC_PAUSE]);
        end
    end

    // First-cycle guard: armed on unpause, spent by one run cycle
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            first_q <= 1'b1;
        end else if (wr_hc && !hwdata[HC_PAUSE]) begin
            first_q <= 1'b1;
        end else if (run) begin
            first_q <= 1'b0;
        end
    end

    // Sequencer control; program reset is a strobe and is not stored
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pcr_q <= PROG_CTRL_RST;
        end else if (wr_pcr) begin
            pcr_q <= hwdata[7:0];
            pcr_q[PC_PROG_RST] <= 1'b0;
        end
    end

    // Breakpoint address
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            brk_lo_q <= BRK_LOW_RST;
            brk_hi_q <= BRK_HIGH_RST;
        end else begin
            if (wr_bl) begin
                brk_lo_q <= hwdata[7:0];
            end
            if (wr_bh) begin
                brk_hi_q <= hwdata[7:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Program counter and load byte index
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pc_q   <= '0;
            bidx_q <= '0;
        end else if (chip_rst || (wr_pcr && hwdata[PC_PROG_RST])) begin
            pc_q   <= '0;
            bidx_q <= '0;
        end else if (wr_pcl && host_ok) begin
            pc_q[7:0] <= hwdata[7:0];
            bidx_q    <= '0;
        end else if (wr_pch && host_ok) begin
            pc_q[PC_W-1:8] <= hwdata[HI_W-1:0];
            bidx_q         <= '0;
        end else if (wr_ram && host_ok && pcr_q[PC_RAM_LOAD]) begin
            // Fill lanes from the least significant, then move on
            if (bidx_q == BI_W'(WORD_BYTES - 1)) begin
                bidx_q <= '0;
                pc_q   <= pc_q + 1'b1;
            end else begin
                bidx_q <= bidx_q + 1'b1;
            end
        end else if (run && jump_low_we) begin
            pc_q[7:0] <= jump_data;
        end else if (run && jump_high_we) begin
            pc_q[PC_W-1:8] <= jump_data[HI_W-1:0];
        end else if (run && !brk_hit && !fault_hit) begin
            pc_q <= pc_q + 1'b1;
        end
    end

    // Load write: one lane with its parity bit
    always_comb begin
        ram_be = '0;
        ram_wd = '0;
        for (int i = 0; i < WORD_BYTES; i++) begin
            ram_wd[i*9 +: 9] = {^hwdata[7:0], hwdata[7:0]};
        end
        if (wr_ram && host_ok && pcr_q[PC_RAM_LOAD]) begin
            ram_be[bidx_q] = 1'b1;
        end
    end

    microcode_mem #(
        .AW    (PC_W),
        .LANES (WORD_BYTES)
    ) u_mem (
        .clk   (clk),
        .waddr (pc_q),
        .wbe   (ram_be),
        .wdata (ram_wd),
        .raddr (pc_q),
        .rdata (instr)
    );

    // Executed address tracks the fetch one cycle later
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            exec_v_q <= 1'b0;
            exec_pc  <= '0;
        end else begin
            exec_v_q <= run && !brk_hit && !fault_hit;
            exec_pc  <= pc_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Break flag, fault latch and causes; set wins over clear
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            brk_flag_q <= 1'b0;
            fault_q    <= 1'b0;
            err_q      <= 3'h0;
        end else if (brk_hit || fault_hit) begin
            brk_flag_q <= 1'b1;
            if (fault_hit) begin
                fault_q <= 1'b1;
                err_q   <= err_q | {par_err, illegal_access, ill_op};
            end
        end else if (chip_rst) begin
            brk_flag_q <= 1'b0;
            fault_q    <= 1'b0;
            err_q      <= 3'h0;
        end else if (wr_clr && hwdata[IC_BRK_CLEAR] && !fault_q) begin
            brk_flag_q <= 1'b0;
        end
    end

    // Interrupt: enabled breakpoint, or any fault regardless of enable
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= brk_flag_q && (pcr_q[PC_BRK_IRQEN] || fault_q);
        end
    end

    // Outputs straight from flops
    always_comb begin
        hrdata     = hrdata_q;
        hreadyout  = hready_q;
        hresp      = hresp_q;
        irq        = irq_q;
        power_down = hc_q[HC_POWER_DN];
        halt_ack   = halt_ack_q;
    end

endmodule
`default_nettype wire

// ===== inc/seq_ctrl_pkg.sv
// Constants for the microcode sequencer host control block: register map,
// bit positions, reset values and default sizes.
// Assumes a 32-bit AHB-Lite register bus with one register per aligned word.
package seq_ctrl_pkg;

    // Register byte offsets on the bus
    localparam logic [7:0] OFF_HOST_CTRL  = 8'h00;  // host_control_reg
    localparam logic [7:0] OFF_PROG_CTRL  = 8'h04;  // program_control_reg
    localparam logic [7:0] OFF_PC_LOW     = 8'h08;  // program_counter_low
    localparam logic [7:0] OFF_PC_HIGH    = 8'h0c;  // program_counter_high
    localparam logic [7:0] OFF_RAM_PORT   = 8'h10;  // microcode_ram_port
    localparam logic [7:0] OFF_BRK_LOW    = 8'h14;  // break_address_low
    localparam logic [7:0] OFF_BRK_HIGH   = 8'h18;  // break_address_high
    localparam logic [7:0] OFF_INT_STATUS = 8'h1c;  // interrupt_status_reg
    localparam logic [7:0] OFF_INT_CLEAR  = 8'h20;  // interrupt_clear_reg
    localparam logic [7:0] OFF_ERROR      = 8'h24;  // fault cause register

    // host_control_reg fields
    localparam int HC_CHIP_RST  = 0;  // whole_chip_reset
    localparam int HC_HALT_ACK  = 1;  // halt_acknowledge, read only
    localparam int HC_PAUSE     = 2;
    localparam int HC_POWER_DN  = 6;  // power_down_bit

    // program_control_reg fields
    localparam int PC_RAM_LOAD  = 0;  // ram_load_enable
    localparam int PC_PROG_RST  = 1;  // program_reset_bit, self clearing
    localparam int PC_BRK_IRQEN = 3;  // break_irq_enable
    localparam int PC_STEP      = 4;
    localparam int PC_FAULT_DIS = 5;  // fault_detect_disable
    localparam int PC_PAR_EN    = 7;  // parity check enable

    // Break address high byte and status / clear / error fields
    localparam int BRK_DISABLE   = 7;  // break_disable
    localparam int IS_BRK_EVENT  = 3;  // break_event_flag
    localparam int IC_BRK_CLEAR  = 3;  // break_event_clear
    localparam int ERR_ILL_OP    = 0;
    localparam int ERR_ILL_ADDR  = 1;
    localparam int ERR_PARITY    = 2;

    // Reset values: sequencer comes up paused so it can be loaded
    localparam logic [7:0] HOST_CTRL_RST = 8'h04;
    localparam logic [7:0] PROG_CTRL_RST = 8'h00;
    localparam logic [7:0] BRK_HIGH_RST  = 8'h80;  // breakpoint disabled
    localparam logic [7:0] BRK_LOW_RST   = 8'h00;

    // Default sizes
    localparam int DEF_PC_W       = 10;           // 4 pages of 256 words
    localparam int DEF_WORD_BYTES = 4;            // bytes per instruction
    localparam int DEF_OP_LIMIT   = 8'hf0;        // opcodes at or above are illegal

    // AHB transfer type bit that marks NONSEQ/SEQ
    localparam int HTRANS_ACTIVE  = 1;

endpackage

// ===== verilog/microcode_mem.sv
// Program store for the sequencer: one word per address, byte lanes of
// 8 data bits plus one parity bit each, registered read.
// Assumes a single clock; write and read in the same cycle return old data.
`timescale 1ns/1ps
`default_nettype none
module microcode_mem #(
    parameter int AW    = 10,  // Address width
    parameter int LANES = 4    // Byte lanes per word
) (
    input  wire logic                 clk,
    input  wire logic [AW-1:0]        waddr,
    input  wire logic [LANES-1:0]     wbe,
    input  wire logic [LANES*9-1:0]   wdata,
    input  wire logic [AW-1:0]        raddr,
    output logic      [LANES*9-1:0]   rdata
);

    // Storage array, no reset: contents are loaded by the driver
    logic [LANES*9-1:0] mem [0:(1<<AW)-1];

    ////////////////////////////////////////////////////////////////////////////
    // Lane-wise write, one lane per load byte
    always_ff @(posedge clk) begin
        for (int i = 0; i < LANES; i++) begin
            if (wbe[i]) begin
                mem[waddr][i*9 +: 9] <= wdata[i*9 +: 9];
            end
        end
    end

    // Registered read so fetched data leave a flop
    always_ff @(posedge clk) begin
        rdata <= mem[raddr];
    end

endmodule
`default_nettype wire

// ===== verilog/fault_check.sv
// Checks one fetched instruction word for an illegal opcode and a parity
// error in any byte lane; combinational.
// Assumes the opcode sits in the top byte and parity is even per lane.
`timescale 1ns/1ps
`default_nettype none
module fault_check #(
    parameter int       LANES    = 4,
    parameter int       OP_LIMIT = 240  // First illegal opcode value
) (
    input  wire logic [LANES*9-1:0] word,
    input  wire logic               parity_en,
    output logic                    illegal_op,
    output logic                    parity_err
);

    logic [7:0] opcode;  // Top data byte of the word

    ////////////////////////////////////////////////////////////////////////////
    // Opcode range and lane parity
    always_comb begin
        opcode     = word[(LANES-1)*9 +: 8];
        illegal_op = ({24'h0, opcode} >= 32'(OP_LIMIT));
        parity_err = 1'b0;
        // Each stored parity bit makes its lane even
        for (int i = 0; i < LANES; i++) begin
            if (^word[i*9 +: 9]) begin
                parity_err = parity_en;
            end
        end
    end

endmodule
`default_nettype wire

// ===== dv/seq_host_ctrl_props.sv
// Checker for the sequencer host control block: bus timing and halt status.
// Assumes one clock, reset async active high, hready tied to hreadyout.
`timescale 1ns/1ps
`default_nettype none
module seq_host_ctrl_props (
    input wire logic        clk,
    input wire logic        reset,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic        irq,
    input wire logic        power_down,
    input wire logic        halt_ack
);
    logic wr_hc_q;  // Data phase of a host control write
    logic rd_q;     // Wait cycle of a read
    ////////////////////////////////////////////////////////////////////////
    // Track data phases so data-phase values can be tied to their effect
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            wr_hc_q <= 1'b0;
            rd_q    <= 1'b0;
        end else begin
            wr_hc_q <= hsel && hready && htrans[1] && hwrite && (haddr[7:2] == 6'h0);
            rd_q    <= hsel && hready && htrans[1] && !hwrite;
        end
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);
    ////////////////////////////////////////////////////////////////////////
    AST_ONE_WAIT: assert property (
        hsel && hready && htrans[1] |=> !hreadyout ##1 hreadyout)
        else $error("transfer not answered after one wait state");
    AST_OKAY: assert property (
        !hresp) else $error("error response seen");
    AST_POWER: assert property (
        wr_hc_q |=> power_down == $past(hwdata[6])) else $error("power down bit not taken");
    AST_PAUSE_ACK: assert property (
        wr_hc_q && hwdata[2] && !hwdata[0] |=> ##[1:2] halt_ack) else $error("pause not acknowledged");
    AST_UNPAUSE: assert property (
        wr_hc_q && !hwdata[2] && !hwdata[0] |=> !halt_ack) else $error("unpause did not run");
    AST_READ_HOLD: assert property (
        !rd_q |=> $stable(hrdata)) else $error("read data changed outside a read");
    AST_IRQ_HALT: assert property (
        $rose(irq) |-> ##[0:2] halt_ack) else $error("interrupt without pause");
    AST_RESET_OUT: assert property (disable iff (1'b0)
        reset |-> !irq && !power_down && !halt_ack && hreadyout) else $error("bad output in reset");
    AST_WAKE_PAUSED: assert property (
        $fell(reset) |=> halt_ack) else $error("not paused after reset");
endmodule
bind seq_host_ctrl seq_host_ctrl_props u_seq_host_ctrl_props (.clk(clk), .reset(reset), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .irq(irq), .power_down(power_down), .halt_ack(halt_ack));
`default_nettype wire

// ===== dv/sequencer_host_control_test.sv
// Self-checking bench for the sequencer host control block.
// Bench is the only AHB-Lite master; sequencer side inputs idle except for the jump and illegal_access pulses.
`timescale 1ns/1ps
`default_nettype none
module sequencer_host_control_test;
    import seq_ctrl_pkg::*;
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin errors++; \
    $display("mismatch %s exp %h got %h", n, e, s); end end
    typedef struct packed {logic [7:0] a; logic w; logic [7:0] d; logic [31:0] e;} row_t;
    logic        clk = 1'b0, reset, hsel = 1'b0, hwrite = 1'b0, hready;  // Reset rises at time zero
    logic        jump_low_we = 1'b0, jump_high_we = 1'b0, illegal_access = 1'b0;
    logic [7:0]  jump_data = 8'h00;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  hsize = 3'h2;
    logic        hreadyout, hresp, irq, power_down, halt_ack;
    logic [9:0]  exec_pc;
    logic [35:0] instr;
    int          errors = 0, total_checks = 0, cyc = 0;
    // Register map after reset: address, write?, data, expected read
    row_t rows [9] = '{'{8'h00, 1'b0, 8'h00, 32'h6}, '{8'h04, 1'b0, 8'h00, 32'h0},
        '{8'h18, 1'b0, 8'h00, 32'h80}, '{8'h1c, 1'b0, 8'h00, 32'h0}, '{8'h24, 1'b0, 8'h00, 32'h0},
        '{8'h14, 1'b1, 8'h5a, 32'h5a}, '{8'h28, 1'b1, 8'h33, 32'h0}, '{8'h20, 1'b1, 8'h08, 32'h0},
        '{8'h10, 1'b0, 8'h00, 32'h0}};
    assign hready = hreadyout;
    always #5 clk = ~clk;
    seq_host_ctrl u_seq_host_ctrl (.clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .illegal_access(illegal_access), .jump_low_we(jump_low_we),
        .jump_high_we(jump_high_we), .jump_data(jump_data), .irq(irq), .power_down(power_down),
        .halt_ack(halt_ack), .exec_pc(exec_pc), .instr(instr));
    ////////////////////////////////////////////////////////////////////////
    // One single AHB transfer; waits on hready, no fixed latency assumed
    task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        r = hrdata;
    endtask
    task automatic chk(input logic [7:0] a, input logic [31:0] e, input string n);
        bus(a, 1'b0, 8'h00);
        `CHK(n, e, r)
    endtask
    // Skip the cycles where the old acknowledge may still show
    task automatic wait_halt;
        repeat (2) @(posedge clk);
        for (int k = 0; k < 200 && halt_ack !== 1'b1; k++) @(posedge clk);
        `CHK("halt_ack", 1'b1, halt_ack)
    endtask
    task automatic final_report;
        if (errors == 0 && total_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // Cut a hang short
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            errors++;
            final_report();
        end
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        // A real edge on reset clears the flops before the first clock
        reset <= 1'b1;
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        repeat (2) @(posedge clk);
        foreach (rows[i]) begin
            if (rows[i].w) bus(rows[i].a, 1'b1, rows[i].d);
            chk(rows[i].a, rows[i].e, "row");
        end
        bus(8'h04, 1'b1, 8'h01);
        bus(8'h08, 1'b1, 8'h00);
        bus(8'h0c, 1'b1, 8'h00);
        // Eight words, opcodes legal except word 7, whose last byte is illegal
        for (int i = 0; i < 32; i++) bus(8'h10, 1'b1, (i == 31) ? 8'hf0 : 8'(i));
        chk(8'h08, 32'h8, "pc_after_load");
        bus(8'h08, 1'b1, 8'h00);
        repeat (3) @(posedge clk);
        `CHK("instr_lane1", 8'h01, instr[16:9])
        bus(8'h04, 1'b1, 8'h08);
        bus(8'h14, 1'b1, 8'h05);
        bus(8'h18, 1'b1, 8'h00);
        bus(8'h00, 1'b1, 8'h00);
        wait_halt();
        chk(8'h08, 32'h5, "brk_pc");
        chk(8'h1c, 32'h8, "brk_flag");
        `CHK("irq_on", 1'b1, irq)
        `CHK("exec_pc", 10'h5, exec_pc)
        bus(8'h20, 1'b1, 8'h08);
        chk(8'h1c, 32'h0, "flag_clr");
        `CHK("irq_off", 1'b0, irq)
        bus(8'h04, 1'b1, 8'h18);
        bus(8'h00, 1'b1, 8'h00);
        wait_halt();
        chk(8'h08, 32'h6, "step_pc");
        bus(8'h04, 1'b1, 8'h02);
        chk(8'h08, 32'h0, "seq_reset_pc");
        // Restart at 6 with a break at 2: only a start below 2 hits it
        bus(8'h14, 1'b1, 8'h02);
        bus(8'h08, 1'b1, 8'h06);
        bus(8'h0c, 1'b1, 8'h00);
        bus(8'h00, 1'b1, 8'h00);
        wait_halt();
        chk(8'h24, 32'h1, "fault_cause");
        `CHK("fault_irq", 1'b1, irq)
        bus(8'h20, 1'b1, 8'h08);
        chk(8'h1c, 32'h8, "fault_sticky");
        bus(8'h00, 1'b1, 8'h05);
        bus(8'h00, 1'b1, 8'h04);
        chk(8'h24, 32'h0, "err_cleared");
        chk(8'h1c, 32'h0, "flag_cleared");
        bus(8'h04, 1'b1, 8'h20);
        bus(8'h18, 1'b1, 8'h80);
        bus(8'h08, 1'b1, 8'h06);
        bus(8'h00, 1'b1, 8'h00);
        repeat (10) @(posedge clk);
        bus(8'h00, 1'b1, 8'h04);
        bus(8'h00, 1'b1, 8'h44);
        wait_halt();
        chk(8'h24, 32'h0, "masked_fault");
        `CHK("masked_irq", 1'b0, irq)
        `CHK("power_down", 1'b1, power_down)
        // Indirect jumps while running; a host counter write is ignored then
        bus(8'h00, 1'b1, 8'h00);
        jump_low_we <= 1'b1;
        jump_data <= 8'h10;
        @(posedge clk);
        jump_low_we <= 1'b0;
        jump_high_we <= 1'b1;
        jump_data <= 8'h02;
        @(posedge clk);
        jump_high_we <= 1'b0;
        bus(8'h0c, 1'b1, 8'h01);
        bus(8'h00, 1'b1, 8'h04);
        chk(8'h0c, 32'h2, "jump_bank");
        chk(8'h08, 32'h15, "jump_low");
        // Reset while paused: back to paused with the counter at zero
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        chk(8'h00, 32'h6, "reset_host");
        chk(8'h0c, 32'h0, "reset_pc");
        // Datapath address fault right after the first executed word
        bus(8'h00, 1'b1, 8'h00);
        illegal_access <= 1'b1;
        @(posedge clk);
        illegal_access <= 1'b0;
        chk(8'h24, 32'h2, "bad_access");
        final_report();
    end
endmodule
`default_nettype wire
